/* File: test/bigc_bus_model.sv */
// far-side model: telegram sink with optional stall and telegram source
`timescale 1ns/1ps
module bigc_bus_model import bigc_pkg::*; (
  // clock and reset
  input  wire logic     clk,
  input  wire logic     rst,
  // telegram sink
  input  wire bigc_tx_t txTel,
  output logic          txReady,
  // telegram source
  output bigc_rx_t      rxTel,
  // stall request from the bench
  input  wire logic     slow
);
  int         rxCount;
  logic [7:0] got [$];

  // sink takes a word at each ready edge; frames of any length pass
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txReady <= 1'b1;
      rxCount <= 0;
    end else begin
      txReady <= slow ? ~txReady : 1'b1;
      if (txTel.valid && txReady) begin
        rxCount <= rxCount + 1;
        got.push_back(txTel.data);
      end
    end
  end

  // source idles with no telegram
  initial rxTel = '0;

  // one-cycle received telegram, launched just after an edge
  task automatic send_rx(input bigc_rx_t t);
    @(posedge clk);
    rxTel <= t;
    @(posedge clk);
    rxTel <= '0;
  endtask
endmodule

/* File: test/binary_input_general_control_bench.sv */
// self-checking bench for the general control block
`timescale 1ns/1ps
module binary_input_general_control_bench import bigc_pkg::*;;
  localparam int SECS = 20;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err, slow;
  logic        busPowerOk, progButton, frontBtnA, frontBtnB, factoryReset;
  logic        progMode, progLedRed, modeLedRed, manualMode, progAccept, keyIsFactory, switchRxOk, txReady;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  inputs, longPress;
  logic [1:0]  chanLed;
  bigc_rx_t    rxTel;
  bigc_tx_t    txTel;
  int          n_mismatch, cmp_count, c, lim;

  // block under test with shortened time base
  bigc_top #(.SEC_CYCLES(SECS), .MS_CYCLES(2), .QDEPTH(8)) DUT (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busPowerOk(busPowerOk),
    .progButton(progButton), .frontBtnA(frontBtnA), .frontBtnB(frontBtnB), .factoryReset(factoryReset),
    .inputs(inputs), .rxTel(rxTel), .txReady(txReady), .txTel(txTel), .progMode(progMode),
    .progLedRed(progLedRed), .modeLedRed(modeLedRed), .manualMode(manualMode), .chanLed(chanLed),
    .longPress(longPress), .progAccept(progAccept), .keyIsFactory(keyIsFactory), .switchRxOk(switchRxOk)
  );

  // bus and tool on the far side
  bigc_bus_model farSide (
    .clk(clk), .rst(rst), .txTel(txTel), .txReady(txReady), .rxTel(rxTel), .slow(slow)
  );

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // verdict and end of run
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one comparison
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // idle clock cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // received telegram, then let the registered answer land
  task automatic rx(input bigc_rx_t t);
    farSide.send_rx(t);
    #1;
  endtask

  // both front buttons pressed together
  task automatic combo();
    @(posedge clk);
    frontBtnA <= 1'b1;
    frontBtnB <= 1'b1;
    cyc(3);
    frontBtnA <= 1'b0;
    frontBtnB <= 1'b0;
    cyc(3);
  endtask

  // recessed button press
  task automatic press();
    @(posedge clk);
    progButton <= 1'b1;
    cyc(3);
    progButton <= 1'b0;
    cyc(3);
  endtask

  // hold one front button with a long press on the first input
  task automatic hold(input int n);
    @(posedge clk);
    frontBtnA <= 1'b1;
    inputs <= 4'h1;
    while (manualMode !== 1'b1 && n > 0) begin
      @(posedge clk);
      n--;
    end
    frontBtnA <= 1'b0;
    inputs <= 4'h0;
    cyc(2);
  endtask

  // main sequence
  initial begin
    {clk, psel, penable, pwrite, progButton, frontBtnA, frontBtnB, factoryReset, slow} = '0;
    {paddr, pwdata, inputs, n_mismatch, cmp_count} = '0;
    busPowerOk = 1'b1;
    rst = 1'b1;
    cyc(3);
    rst <= 1'b0;
    // reset values, unmapped access, read-back
    apb(0, REG_CTRL, 0);
    chk("ctrl", rd, CTRL_RST);
    apb(0, REG_CFG, 0);
    chk("cfg", rd, CFG_RST);
    apb(0, REG_STATUS, 0);
    chk("status", rd, 32'h0000_0040);
    apb(0, 8'h30, 0);
    chk("unmapped error", err, 1);
    chk("unmapped data", rd, 0);
    apb(1, REG_CFG, 32'h0001_0102);
    apb(0, REG_CFG, 0);
    chk("cfg", rd, 32'h0001_0102);
    // programming mode toggles
    press();
    chk("prog leds", {progMode, progLedRed, modeLedRed}, 3'h7);
    combo();
    chk("prog front off", progMode, 1);
    apb(1, REG_CTRL, 32'h0000_0001);
    combo();
    chk("prog front on", {progMode, progLedRed, modeLedRed}, 0);
    press();
    chk("prog button", progMode, 1);
    press();
    apb(1, REG_CTRL, 0);
    // shared long-press time
    inputs <= 4'hF;
    cyc(190);
    chk("long early", longPress, 0);
    cyc(20);
    chk("long all", longPress, 4'hF);
    inputs <= 4'h0;
    cyc(8);
    // send delay after power return
    slow <= 1'b1;
    busPowerOk <= 1'b0;
    cyc(4);
    busPowerOk <= 1'b1;
    c = farSide.rxCount;
    apb(1, REG_TXDATA, 32'h11);
    apb(1, REG_TXDATA, 32'h22);
    rx(bigc_rx_t'{valid: 1'b1, isSwitch: 1'b1, default: '0});
    chk("rx during delay", switchRxOk, 1);
    apb(0, REG_STATUS, 0);
    chk("delay running", rd[7], 1);
    chk("held sends", farSide.rxCount, c);
    cyc(60);
    chk("released sends", farSide.rxCount, c + 2);
    chk("first out", farSide.got[c], 8'h11);
    chk("second out", farSide.got[c+1], 8'h22);
    slow <= 1'b0;
    // channel functions and cycle counters
    for (int f = 0; f < 8; f++) begin
      apb(1, REG_CHFUNC, {20'h0, {4{f[2:0]}}});
      apb(0, REG_CHFUNC, 0);
      chk("chfunc", rd, {20'h0, {4{f[2:0]}}});
    end
    apb(1, REG_CHFUNC, 32'h0000_01CE);
    repeat (3) begin
      inputs <= 4'hF;
      cyc(4);
      inputs <= 4'h0;
      cyc(4);
    end
    for (int i = 0; i < 4; i++) begin
      apb(0, REG_CNT0 + 8'(4 * i), 0);
      chk("counter", rd, (i % 2 == 0) ? 3 : 0);
    end
    apb(1, REG_CNTCLR, 1);
    apb(0, REG_CNT0, 0);
    chk("counter cleared", rd, 0);
    apb(0, REG_CNT0 + 8'h08, 0);
    chk("counter kept", rd, 3);
    // led sources
    for (int s = 1; s < 5; s++) begin
      apb(1, REG_CTRL, (s << 8) | (s << 12));
      inputs <= 4'h1 << (s - 1);
      cyc(4);
      chk("led mirror on", chanLed, 2'h3);
      inputs <= ~(4'h1 << (s - 1));
      cyc(4);
      chk("led mirror off", chanLed, 2'h0);
    end
    apb(1, REG_CTRL, 32'h0000_0500);
    inputs <= 4'hF;
    rx(bigc_rx_t'{valid: 1'b1, ledObj: 1'b1, value: 1'b1, default: '0});
    cyc(2);
    chk("led object", chanLed, 2'h1);
    inputs <= 4'h0;
    cyc(4);
    chk("led object kept", chanLed, 2'h1);
    rx(bigc_rx_t'{valid: 1'b1, ledObj: 1'b1, default: '0});
    cyc(2);
    chk("led object off", chanLed, 2'h0);
    // encrypted programming and commissioning key
    rx(bigc_rx_t'{valid: 1'b1, isProg: 1'b1, default: '0});
    chk("plain prog", progAccept, 0);
    rx(bigc_rx_t'{valid: 1'b1, isProg: 1'b1, encrypted: 1'b1, default: '0});
    chk("secure prog", progAccept, 1);
    apb(1, REG_KEYSEL, 0);
    cyc(1);
    chk("device key", keyIsFactory, 0);
    @(posedge clk);
    factoryReset <= 1'b1;
    cyc(3);
    factoryReset <= 1'b0;
    cyc(3);
    chk("factory key", keyIsFactory, 1);
    // manual mode settings and time limits
    apb(1, REG_CTRL, 0);
    hold(300);
    chk("manual off", manualMode, 0);
    for (int s = 1; s < 4; s++) begin
      apb(1, REG_CTRL, s << 4);
      lim = (s == 1 ? LIM1_MIN : s == 2 ? LIM10_MIN : LIM30_MIN) * MIN_S * SECS;
      hold(600);
      if (s == 1) begin
        rx(bigc_rx_t'{valid: 1'b1, isSwitch: 1'b1, default: '0});
        chk("switch dropped", switchRxOk, 0);
      end
      cyc(lim - 40);
      chk("manual held", manualMode, 1);
      c = farSide.rxCount;
      cyc(70);
      chk("manual expired", manualMode, 0);
    end
    cyc(50);
    chk("quiet after manual", farSide.rxCount, c);
    inputs <= 4'h2;
    cyc(10);
    chk("send on change", farSide.rxCount, c + 1);
    inputs <= 4'h0;
    apb(1, REG_CTRL, 32'h0000_0040);
    hold(600);
    cyc(lim / 20);
    chk("manual free", manualMode, 1);
    combo();
    chk("manual combo exit", manualMode, 0);
    // heartbeat of one minute
    apb(1, REG_CTRL, 32'h0000_0002);
    cyc(100);
    c = farSide.rxCount;
    cyc(MIN_S * SECS);
    chk("heartbeat", farSide.rxCount - c, 1);
    chk("heartbeat bit", farSide.got[c][7], 1);
    wrap_up();
  end
endmodule

/* File: verilog/bigc_pkg.sv */
// package of constants, types and register map for the binary input general control
// Behaviour
// - after bus power returns, outgoing telegrams wait the configured send delay
// - during that delay receiving and input sampling continue normally
// - front button pair toggles programming mode only when front option enabled
// - recessed programming button always toggles programming mode
// - manual mode setting: disabled, 1, 10, 30 minute limit, or unlimited
// - configured limit expiry ends manual mode, back to normal operation
// - pressing both front buttons also ends manual mode
// - switching telegrams from the bus are dropped while manual mode active
// - after manual mode ends, next telegram only on next input change
// - enabled heartbeat sends a one-bit trigger every selected cycle time
// - heartbeat settings also drive cyclic sends of state-query channels
// - one long-press time applies equally to all four inputs
// - each LED: off, mirror one input, or driven by bus object
// - in bus-object mode LED follows received value only
// - four identical, independently configured input channels
// - channel function: off, switch, dim, shutter, value, scene, impulse, time counter
// - counter channels keep a readable, resettable switching-cycle count
// - bus programming accepted only in encrypted telegrams
// - factory reset makes factory setup key the active key again
// - programming mode lights programming indicator and mode indicator red
package bigc_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_CFG     = 8'h04;
  localparam logic [7:0] REG_CHFUNC  = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0C;
  localparam logic [7:0] REG_CNT0    = 8'h10;
  localparam logic [7:0] REG_CNTCLR  = 8'h20;
  localparam logic [7:0] REG_TXDATA  = 8'h24;
  localparam logic [7:0] REG_KEYSEL  = 8'h28;
  // CTRL fields
  localparam int CTRL_FRONTPROG = 0;
  localparam int CTRL_HBEN      = 1;
  localparam int CTRL_MANUAL_LO = 4;
  localparam int CTRL_LED0_LO   = 8;
  localparam int CTRL_LED1_LO   = 12;
  // CFG fields
  localparam int CFG_DELAY_LO  = 0;
  localparam int CFG_LONG_LO   = 8;
  localparam int CFG_HBCYC_LO  = 16;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  // timing: one second tick at 200 MHz
  localparam int CLK_HZ      = 200000000;
  localparam int SEC_S       = 1;
  localparam int SEC_CYC     = CLK_HZ * SEC_S;
  localparam int MS_CYC      = CLK_HZ / 1000;
  localparam int LONG_STEP_MS = 100;
  localparam int MIN_S       = 60;
  localparam int LIM1_MIN    = 1;
  localparam int LIM10_MIN   = 10;
  localparam int LIM30_MIN   = 30;
  localparam int HB_MAX_MIN  = 1440;
  // manual mode settings
  typedef enum logic [2:0] {MAN_OFF, MAN_1, MAN_10, MAN_30, MAN_FREE} bigc_man_t;
  // led source settings
  typedef enum logic [2:0] {LED_OFF, LED_A1, LED_A2, LED_B1, LED_B2, LED_OBJ} bigc_led_t;
  // channel functions
  typedef enum logic [2:0] {
    FN_OFF, FN_SWITCH, FN_DIM, FN_SHUTTER, FN_VALUE, FN_SCENE, FN_IMPULSE, FN_OPTIME
  } bigc_fn_t;
  // received telegram summary
  typedef struct packed {
    logic       valid;
    logic       isSwitch;
    logic       isProg;
    logic       encrypted;
    logic       ledObj;
    logic [1:0] ledIdx;
    logic       value;
  } bigc_rx_t;
  // outgoing telegram word
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } bigc_tx_t;
endpackage

/* File: verilog/bigc_top.sv */
// general control block of the four-channel binary input
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module bigc_top import bigc_pkg::*; #(
  parameter int SEC_CYCLES = SEC_CYC,
  parameter int MS_CYCLES  = MS_CYC,
  parameter int QDEPTH     = 8
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // bus power, front panel, inputs
  input  wire logic        busPowerOk,
  input  wire logic        progButton,
  input  wire logic        frontBtnA,
  input  wire logic        frontBtnB,
  input  wire logic        factoryReset,
  input  wire logic [3:0]  inputs,
  // received telegram summary
  input  wire bigc_rx_t    rxTel,
  // outgoing telegram
  input  wire logic        txReady,
  output bigc_tx_t         txTel,
  // indicators and status
  output logic             progMode,
  output logic             progLedRed,
  output logic             modeLedRed,
  output logic             manualMode,
  output logic [1:0]       chanLed,
  output logic [3:0]       longPress,
  output logic             progAccept,
  output logic             keyIsFactory,
  output logic             switchRxOk
);
  localparam int QW = $clog2(QDEPTH);
  logic [31:0] ctrlReg;
  logic [31:0] cfgReg;
  logic [31:0] chFuncReg;
  logic [15:0] cntReg [4];
  logic [3:0]  inPrev;
  logic        bothPrev;
  logic        progPrev;
  logic        bothPress;
  logic        progPress;
  logic [27:0] secDiv;
  logic        secTick;
  logic [7:0]  delayCnt;
  logic        delayRun;
  logic        powerPrev;
  logic [11:0] manSec;
  logic [16:0] hbSec;
  logic [1:0]  objLed;
  logic [7:0]  qMem [QDEPTH];
  logic [QW:0] qWr;
  logic [QW:0] qRd;
  logic        apbWr;
  logic        apbRd;
  logic [3:0]  inChange;
  logic [3:0]  inSend;
  logic        manEnd;
  logic [32:0] pressCnt [4];
  logic        hbFire;
  bigc_man_t   manSet;

  // apb decode
  assign apbWr     = psel & penable & pwrite;
  assign apbRd     = psel & penable & ~pwrite;
  assign bothPress = frontBtnA & frontBtnB & ~bothPrev;
  assign progPress = progButton & ~progPrev;
  assign inChange  = inputs ^ inPrev;
  assign manSet    = bigc_man_t'(ctrlReg[CTRL_MANUAL_LO +: 3]);

  // limit in seconds for a manual mode setting
  function automatic logic [11:0] manLimit(input bigc_man_t m);
    case (m)
      MAN_1:   manLimit = 12'(LIM1_MIN * MIN_S);
      MAN_10:  manLimit = 12'(LIM10_MIN * MIN_S);
      MAN_30:  manLimit = 12'(LIM30_MIN * MIN_S);
      default: manLimit = 12'h000;
    endcase
  endfunction

  // led level for a source setting
  function automatic logic ledLevel(input logic [2:0] s, input logic [3:0] in, input logic obj);
    case (bigc_led_t'(s))
      LED_A1:  ledLevel = in[0];
      LED_A2:  ledLevel = in[1];
      LED_B1:  ledLevel = in[2];
      LED_B2:  ledLevel = in[3];
      LED_OBJ: ledLevel = obj;
      default: ledLevel = 1'b0;
    endcase
  endfunction

  // one-second enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      secDiv  <= 28'h0000000;
      secTick <= 1'b0;
    end else if (secDiv == 28'(SEC_CYCLES - 1)) begin
      secDiv  <= 28'h0000000;
      secTick <= 1'b1;
    end else begin
      secDiv  <= secDiv + 28'h0000001;
      secTick <= 1'b0;
    end
  end

  // edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inPrev    <= 4'h0;
      bothPrev  <= 1'b0;
      progPrev  <= 1'b0;
      powerPrev <= 1'b0;
    end else begin
      inPrev    <= inputs;
      bothPrev  <= frontBtnA & frontBtnB;
      progPrev  <= progButton;
      powerPrev <= busPowerOk;
    end
  end

  // register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlReg   <= CTRL_RST;
      cfgReg    <= CFG_RST;
      chFuncReg <= 32'h0000_0000;
    end else if (apbWr) begin
      case (paddr)
        REG_CTRL:   ctrlReg   <= pwdata;
        REG_CFG:    cfgReg    <= pwdata;
        REG_CHFUNC: chFuncReg <= {20'h00000, pwdata[11:0]}; // 3 bits per channel
        default:    ;
      endcase
    end
  end

  // apb read and answer, zero wait state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          REG_CTRL:   prdata <= ctrlReg;
          REG_CFG:    prdata <= cfgReg;
          REG_CHFUNC: prdata <= chFuncReg;
          REG_STATUS: prdata <= {24'h000000, delayRun, keyIsFactory, inputs, manualMode, progMode};
          8'h10, 8'h14, 8'h18, 8'h1C: prdata <= {16'h0000, cntReg[paddr[3:2]]};
          default:    prdata <= 32'h0000_0000;
        endcase
      end
      if (psel & ~penable) begin
        pslverr <= !(paddr inside {REG_CTRL, REG_CFG, REG_CHFUNC, REG_STATUS, 8'h10, 8'h14, 8'h18, 8'h1C,
                                   REG_CNTCLR, REG_TXDATA, REG_KEYSEL});
      end
    end
  end

  // programming mode toggle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      progMode <= 1'b0;
    end else if (progPress) begin
      progMode <= ~progMode;
    end else if (bothPress & ctrlReg[CTRL_FRONTPROG] & ~manualMode) begin
      progMode <= ~progMode;
    end
  end

  // programming indicators
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      progLedRed <= 1'b0;
      modeLedRed <= 1'b0;
    end else begin
      progLedRed <= progMode;
      modeLedRed <= progMode;
    end
  end

  // manual mode entry, limit and exit
  assign manEnd = manualMode & (bothPress | ((manSet != MAN_FREE) && (manSec == 12'h000)));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      manualMode <= 1'b0;
      manSec     <= 12'h000;
    end else if (~manualMode) begin
      if ((frontBtnA ^ frontBtnB) & (longPress != 4'h0) & (manSet != MAN_OFF)) begin
        manualMode <= 1'b1;
        manSec     <= manLimit(manSet);
      end
    end else if (manEnd) begin
      manualMode <= 1'b0;
    end else if (secTick & (manSec != 12'h000)) begin
      manSec <= manSec - 12'h001;
    end
  end

  // long press, one shared time for every input; 33 bits hold the longest setting at full clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        pressCnt[i] <= 33'h000000000;
      end
      longPress <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!inputs[i]) begin
          pressCnt[i] <= 33'h000000000;
          longPress[i] <= 1'b0;
        end else if (pressCnt[i] >= 33'(cfgReg[CFG_LONG_LO +: 8]) * 33'(MS_CYCLES * LONG_STEP_MS)) begin
          longPress[i] <= 1'b1;
        end else begin
          pressCnt[i] <= pressCnt[i] + 33'h000000001;
        end
      end
    end
  end

  // send delay after bus power return
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delayRun <= 1'b0;
      delayCnt <= 8'h00;
    end else if (busPowerOk & ~powerPrev) begin
      delayRun <= cfgReg[CFG_DELAY_LO +: 8] != 8'h00;
      delayCnt <= cfgReg[CFG_DELAY_LO +: 8];
    end else if (delayRun & secTick) begin
      delayCnt <= delayCnt - 8'h01;
      delayRun <= delayCnt != 8'h01;
    end
  end

  // heartbeat and state-query cycle
  // seconds down-counter wide enough for a full day
  assign hbFire = ctrlReg[CTRL_HBEN] & secTick & (hbSec == 17'h00000);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hbSec <= 17'h00000;
    end else if (secTick) begin
      if (hbSec == 17'h00000) begin
        hbSec <= 17'(cfgReg[CFG_HBCYC_LO +: 11] * MIN_S - 1);
      end else begin
        hbSec <= hbSec - 17'h00001;
      end
    end
  end

  // which channels send: input change outside manual mode, heartbeat re-send for switching
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      inSend[i] = ~manualMode & inChange[i] & (chFuncReg[3*i +: 3] != 3'(FN_OFF));
      if (hbFire & (chFuncReg[3*i +: 3] == 3'(FN_SWITCH))) begin
        inSend[i] = 1'b1;
      end
    end
  end

  // switching-cycle counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        cntReg[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (apbWr & (paddr == REG_CNTCLR) & pwdata[i]) begin
          cntReg[i] <= 16'h0000;
        end else if (inputs[i] & ~inPrev[i] &
                     ((chFuncReg[3*i +: 3] == 3'(FN_IMPULSE)) | (chFuncReg[3*i +: 3] == 3'(FN_OPTIME)))) begin
          cntReg[i] <= cntReg[i] + 16'h0001;
        end
      end
    end
  end

  // outgoing queue, drained only when the send delay is over
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qWr   <= '0;
      qRd   <= '0;
      txTel <= '0;
      for (int i = 0; i < QDEPTH; i++) begin
        qMem[i] <= 8'h00;
      end
    end else begin
      if ((inSend != 4'h0 | hbFire | (apbWr & (paddr == REG_TXDATA))) &&
          (qWr - qRd) != (QW + 1)'(QDEPTH)) begin
        qMem[qWr[QW-1:0]] <= (apbWr & (paddr == REG_TXDATA)) ? pwdata[7:0] :
                             {hbFire, 3'h0, inSend & inputs};
        qWr <= qWr + 1'b1;
      end
      if (txTel.valid & txReady) begin
        txTel.valid <= 1'b0;
      end else if (~txTel.valid & ~delayRun & (qWr != qRd)) begin
        txTel.valid <= 1'b1;
        txTel.data  <= qMem[qRd[QW-1:0]];
        qRd         <= qRd + 1'b1;
      end
    end
  end

  // received telegrams: switching filter, led object, secure programming, key
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      objLed       <= 2'b00;
      switchRxOk   <= 1'b0;
      progAccept   <= 1'b0;
      keyIsFactory <= 1'b1;
    end else begin
      switchRxOk <= rxTel.valid & rxTel.isSwitch & ~manualMode;
      progAccept <= rxTel.valid & rxTel.isProg & rxTel.encrypted;
      if (rxTel.valid & rxTel.ledObj) begin
        objLed[rxTel.ledIdx[0]] <= rxTel.value;
      end
      if (factoryReset) begin
        keyIsFactory <= 1'b1;
      end else if (apbWr & (paddr == REG_KEYSEL)) begin
        keyIsFactory <= pwdata[0]; // tool installs device key
      end
    end
  end

  // channel leds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chanLed <= 2'b00;
    end else begin
      chanLed[0] <= ledLevel(ctrlReg[CTRL_LED0_LO +: 3], inputs, objLed[0]);
      chanLed[1] <= ledLevel(ctrlReg[CTRL_LED1_LO +: 3], inputs, objLed[1]);
    end
  end

  // programming indicator follows mode
  property p_progLed;
    @(posedge clk) disable iff (rst) progMode |=> progLedRed && modeLedRed;
  endproperty
  a_progLed: assert property (p_progLed) else $error("prog leds not red");

  property p_recessed;
    @(posedge clk) disable iff (rst) progPress |=> progMode != $past(progMode);
  endproperty
  a_recessed: assert property (p_recessed) else $error("recessed button no toggle");

  property p_frontOff;
    @(posedge clk) disable iff (rst) bothPress && !progPress && !ctrlReg[CTRL_FRONTPROG] |=> $stable(progMode);
  endproperty
  a_frontOff: assert property (p_frontOff) else $error("front toggle while disabled");

  property p_noTxDelay;
    @(posedge clk) disable iff (rst) delayRun && !txTel.valid |=> !txTel.valid;
  endproperty
  a_noTxDelay: assert property (p_noTxDelay) else $error("telegram sent in delay");

  property p_manDrop;
    @(posedge clk) disable iff (rst) manualMode |=> !switchRxOk;
  endproperty
  a_manDrop: assert property (p_manDrop) else $error("switch telegram in manual");

  property p_manExit;
    @(posedge clk) disable iff (rst) manualMode && bothPress |=> !manualMode;
  endproperty
  a_manExit: assert property (p_manExit) else $error("manual mode not ended");

  property p_unenc;
    @(posedge clk) disable iff (rst) rxTel.valid && !rxTel.encrypted |=> !progAccept;
  endproperty
  a_unenc: assert property (p_unenc) else $error("plain programming accepted");

  property p_key;
    @(posedge clk) disable iff (rst) factoryReset |=> keyIsFactory;
  endproperty
  a_key: assert property (p_key) else $error("factory key not restored");
endmodule
